// *** inc/ocm_consts.svh ***
// constants of the output channel input matrix: offsets, fields, resets, timing
`ifndef OCM_CONSTS_SVH
`define OCM_CONSTS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OCM_OFF_HW_SETUP 8'h00
`define OCM_OFF_CHAN_SW 8'h04
`define OCM_OFF_IN_EXT_CFG 8'h08
`define OCM_OFF_DIAG_CFG 8'h0C
`define OCM_OFF_PWM_SETUP 8'h10
`define OCM_OFF_PWM_EXT0 8'h14
`define OCM_OFF_PWM_EXT1 8'h18
`define OCM_OFF_STATUS 8'h1C
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OCM_HW_RST_BIT 1
`define OCM_HW_SLEEP_BIT 1
`define OCM_HW_LAMP2_BIT 2
`define OCM_HW_LAMP3_BIT 3
`define OCM_CFG_MAP_BIT 0
`define OCM_CFG_GATE_BIT 1
`define OCM_CFG_COMPAT_BIT 2
`define OCM_PWM_RUN_BIT 0
`define OCM_PWM_PER_LSB 0
`define OCM_PWM_DUTY_LSB 8
// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define OCM_SENSE_DEFAULT 3'h7
`define OCM_SENSE_EXT0 3'h4
`define OCM_SENSE_EXT1 3'h5
`define OCM_PWM_PER_RESET 8'hFF
`define OCM_PWM_DUTY_RESET 8'h00
// ----------------------------------------------------------------
// timing: pwm base tick period in ns and derived clock count
// ----------------------------------------------------------------
`define OCM_CLK_PERIOD_NS 5
`define OCM_PWM_TICK_NS 1000
`define OCM_PWM_DIV (`OCM_PWM_TICK_NS / `OCM_CLK_PERIOD_NS)
`endif

// *** inc/ocm_pkg.sv ***
// types shared by the output channel input matrix modules
package ocm_pkg;
  typedef logic [2:0] ocm_sel_t; // sense selector code
  typedef logic [5:0] ocm_chan_t; // four channels plus two external drivers
  typedef logic [7:0] ocm_byte_t; // pwm period or duty value
endpackage

// *** inc/ocm_pwm_if.sv ***
// carrier between the matrix and its pwm generator
`timescale 1ns/1ps
interface ocm_pwm_if;
  logic run; // pwm run bit
  ocm_pkg::ocm_byte_t period [2]; // ticks per pwm cycle minus one, per driver
  ocm_pkg::ocm_byte_t duty [2]; // on ticks per cycle, per driver
  logic [1:0] pwmOut; // generated waveforms
  modport ctl (output run, output period, output duty, input pwmOut);
  modport gen (input run, input period, input duty, output pwmOut);
endinterface

// *** rtl/ocm_pin_sync.sv ***
// two flip-flop synchroniser for the asynchronous pins
`timescale 1ns/1ps
module ocm_pin_sync (
  input wire logic clock, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic [12:0] pinRaw, // raw pin levels
  output logic [12:0] pinSync // synchronised levels
);
  logic [12:0] stage1_r; // first stage, read only by the second

  // ----------------------------------------------------------------
  // two stages
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stage1_r <= 13'h0000;
      pinSync <= 13'h0000;
    end else begin
      stage1_r <= pinRaw;
      pinSync <= stage1_r;
    end
  end
endmodule

// *** rtl/ocm_pwm_gen.sv ***
// automatic pwm generator for the two external driver outputs
`timescale 1ns/1ps
`include "ocm_consts.svh"
module ocm_pwm_gen (
  input wire logic clock, // system clock
  input wire logic resetn, // async reset, active low
  ocm_pwm_if.gen pwm // settings in, waveforms out
);
  localparam int unsigned DivCount = `OCM_PWM_DIV; // clocks per tick
  logic [15:0] div_r; // tick divider
  logic tick; // one-cycle tick enable

  // ----------------------------------------------------------------
  // tick divider
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_r <= 16'h0000;
    end else if (!pwm.run || div_r == 16'(DivCount - 1)) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end
  assign tick = pwm.run && (div_r == 16'(DivCount - 1));

  // ----------------------------------------------------------------
  // one counter and comparator per driver
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : gDrv
    ocm_pkg::ocm_byte_t cnt_r; // position in pwm cycle
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        cnt_r <= 8'h00;
        pwm.pwmOut[g] <= 1'b0;
      end else begin
        if (!pwm.run) begin
          cnt_r <= 8'h00;
        end else if (tick) begin
          cnt_r <= (cnt_r >= pwm.period[g]) ? 8'h00 : cnt_r + 8'h01;
        end
        pwm.pwmOut[g] <= pwm.run && (cnt_r < pwm.duty[g]);
      end
    end
  end
endmodule

// *** rtl/ocm_output_matrix.sv ***
// output channel input matrix: apb registers, pin mapping, gating, ext drivers
//
// Behaviour
// - writing one to reset trigger resets device
// - sleep flag reads 1 in stand-by
// - four channels switched by bit or pin
// - direct mapping default; assigned when map select
// - gating select 0: bit OR pin
// - gating select 1: bit AND pin
// - direct: pins one-three drive channels 1-3
// - direct: channel 0, ext drivers bit only
// - direct mapping restored after wake and reset
// - assigned: pin one ch0, pin two ch1
// - assigned: pin three drives ch2, ch3, ext
// - lamp type select for channels 2, 3
// - inverse current holds state, no fault
// - per ext driver: drive and diag output
// - ext drive outputs low without logic supply
// - ext drivers from bits 4, 5 or pin three
// - pwm generator also drives ext drivers
// - sense selector can pick either ext driver
// - compat mode: diag lines are enable, choice
// - compat: 100 gives 1/0, 101 gives 1/1
// - reset clears registers, pin channels unaffected
// - stand-by when selector default, no pwm, no pin
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "ocm_consts.svh"
module ocm_output_matrix (
  input wire logic clock, // 200 MHz system clock
  input wire logic resetn, // async reset, active low
  input wire logic [7:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data, registered
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic inPinOne, // parallel input pin one
  input wire logic inPinTwo, // parallel input pin two
  input wire logic inPinThree, // parallel input pin three
  input wire logic limpHomePin, // limp home request pin
  input wire logic logicSupplyOk, // logic supply present
  input wire logic [3:0] inverseCur, // inverse current seen per channel
  input wire logic [3:0] chanFault, // raw fault per channel
  output logic [3:0] chanOn, // channel power stage on
  output logic [1:0] lampLed, // led profile for channels 2, 3
  output logic [1:0] extDriveCtl, // external driver drive control
  output logic [1:0] extDiagEnable, // external driver diag enable
  output logic [3:0] faultFlag, // channel fault flags
  output logic sleepFlag // device in stand-by
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [12:0] pinSync; // synchronised pins
  logic [2:0] pinS; // input pins one to three
  logic limpS; // limp home level
  logic supplyS; // logic supply level
  logic [3:0] inverseS; // inverse current levels
  logic [3:0] faultS; // raw fault levels
  logic [1:0] lampSel_r; // lamp type select, channels 2 and 3
  ocm_pkg::ocm_chan_t swBits_r; // channel switch bits
  logic mapSel_r; // pin map select
  logic gateSel_r; // pin gating select
  logic compat_r; // compatible diagnosis mode
  ocm_pkg::ocm_sel_t senseSel_r; // sense selector
  logic pwmRun_r; // pwm run bit
  ocm_pkg::ocm_byte_t pwmPer_r [2]; // pwm periods
  ocm_pkg::ocm_byte_t pwmDuty_r [2]; // pwm duties
  logic softRst_r; // pending reset trigger
  logic sleep_r; // stand-by state
  logic sleepNxt; // stand-by condition
  logic wake; // leaving stand-by this cycle
  logic regClear; // clear the register bank
  logic wrEn; // write taken this edge
  logic rdSetup; // read setup cycle
  logic addrOk; // address maps to a register
  ocm_pkg::ocm_chan_t pinDrv; // pin drive after mapping
  ocm_pkg::ocm_chan_t pinMask; // which outputs have a pin
  ocm_pkg::ocm_chan_t chanReq; // combined request per output
  logic [3:0] chanOn_r; // channel state
  logic [1:0] extDrive_r; // ext drive state
  logic [1:0] diag_r; // diag line state
  logic [3:0] fault_r; // fault flag state
  ocm_pwm_if pwmBus (); // pwm generator carrier

  // ----------------------------------------------------------------
  // decoding functions
  // ----------------------------------------------------------------
  // map pins to outputs: bits 0-3 channels, 4-5 ext drivers
  function automatic ocm_pkg::ocm_chan_t mapPins(input logic [2:0] pins, input logic assigned);
    ocm_pkg::ocm_chan_t res;
    res = 6'h00;
    if (assigned) begin
      res = {pins[2], pins[2], pins[2], pins[2], pins[1], pins[0]};
    end else begin
      res = {2'b00, pins[2], pins[1], pins[0], 1'b0};
    end
    return res;
  endfunction

  // true when the address names a register
  function automatic logic isReg(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `OCM_OFF_STATUS); // the bank is one run of aligned words
  endfunction

  // ----------------------------------------------------------------
  // pin synchroniser and pwm generator
  // ----------------------------------------------------------------
  ocm_pin_sync uSync (
    .clock(clock),
    .resetn(resetn),
    .pinRaw({chanFault, inverseCur, logicSupplyOk, limpHomePin, inPinThree, inPinTwo, inPinOne}),
    .pinSync(pinSync)
  );
  assign pinS = pinSync[2:0];
  assign limpS = pinSync[3];
  assign supplyS = pinSync[4];
  assign inverseS = pinSync[8:5];
  assign faultS = pinSync[12:9];

  ocm_pwm_gen uPwm (
    .clock(clock),
    .resetn(resetn),
    .pwm(pwmBus)
  );
  assign pwmBus.run = pwmRun_r;
  assign pwmBus.period = pwmPer_r;
  assign pwmBus.duty = pwmDuty_r;

  // ----------------------------------------------------------------
  // apb slave: zero wait states, error on unmapped address
  // ----------------------------------------------------------------
  assign addrOk = isReg(paddr);
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addrOk;
  // writes are ignored in limp home, the bank is held at defaults there
  assign wrEn = psel && penable && pwrite && addrOk && !limpS;
  assign rdSetup = psel && !penable && !pwrite;

  // ----------------------------------------------------------------
  // stand-by detection
  // ----------------------------------------------------------------
  assign sleepNxt = (senseSel_r == `OCM_SENSE_DEFAULT) && !pwmRun_r && (pinS == 3'b000);
  assign wake = sleep_r && !sleepNxt;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sleep_r <= 1'b1;
    end else begin
      sleep_r <= sleepNxt;
    end
  end
  assign sleepFlag = sleep_r;

  // ----------------------------------------------------------------
  // reset trigger: a write of one schedules a bank clear next cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      softRst_r <= 1'b0;
    end else begin
      softRst_r <= wrEn && (paddr == `OCM_OFF_HW_SETUP) && pwdata[`OCM_HW_RST_BIT];
    end
  end
  assign regClear = softRst_r || limpS;

  // ----------------------------------------------------------------
  // hardware setup: lamp type selects
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lampSel_r <= 2'b00;
    end else if (regClear) begin
      lampSel_r <= 2'b00;
    end else if (wrEn && paddr == `OCM_OFF_HW_SETUP) begin
      lampSel_r <= {pwdata[`OCM_HW_LAMP3_BIT], pwdata[`OCM_HW_LAMP2_BIT]};
    end
  end
  assign lampLed = lampSel_r;

  // ----------------------------------------------------------------
  // channel switch bits
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      swBits_r <= 6'h00;
    end else if (regClear) begin
      swBits_r <= 6'h00;
    end else if (wrEn && paddr == `OCM_OFF_CHAN_SW) begin
      swBits_r <= pwdata[5:0];
    end
  end

  // ----------------------------------------------------------------
  // input/external configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mapSel_r <= 1'b0;
      gateSel_r <= 1'b0;
      compat_r <= 1'b0;
    end else if (regClear) begin
      mapSel_r <= 1'b0;
      gateSel_r <= 1'b0;
      compat_r <= 1'b0;
    end else begin
      // wake clears the map select; a write in the same cycle wins
      if (wake) begin
        mapSel_r <= 1'b0;
      end
      if (wrEn && paddr == `OCM_OFF_IN_EXT_CFG) begin
        mapSel_r <= pwdata[`OCM_CFG_MAP_BIT];
        gateSel_r <= pwdata[`OCM_CFG_GATE_BIT];
        compat_r <= pwdata[`OCM_CFG_COMPAT_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // diagnosis configuration and pwm setup
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      senseSel_r <= `OCM_SENSE_DEFAULT;
      pwmRun_r <= 1'b0;
      pwmPer_r <= '{`OCM_PWM_PER_RESET, `OCM_PWM_PER_RESET};
      pwmDuty_r <= '{`OCM_PWM_DUTY_RESET, `OCM_PWM_DUTY_RESET};
    end else if (regClear) begin
      senseSel_r <= `OCM_SENSE_DEFAULT;
      pwmRun_r <= 1'b0;
      pwmPer_r <= '{`OCM_PWM_PER_RESET, `OCM_PWM_PER_RESET};
      pwmDuty_r <= '{`OCM_PWM_DUTY_RESET, `OCM_PWM_DUTY_RESET};
    end else if (wrEn) begin
      case (paddr)
        `OCM_OFF_DIAG_CFG: senseSel_r <= pwdata[2:0];
        `OCM_OFF_PWM_SETUP: pwmRun_r <= pwdata[`OCM_PWM_RUN_BIT];
        `OCM_OFF_PWM_EXT0: begin
          pwmPer_r[0] <= pwdata[`OCM_PWM_PER_LSB +: 8];
          pwmDuty_r[0] <= pwdata[`OCM_PWM_DUTY_LSB +: 8];
        end
        `OCM_OFF_PWM_EXT1: begin
          pwmPer_r[1] <= pwdata[`OCM_PWM_PER_LSB +: 8];
          pwmDuty_r[1] <= pwdata[`OCM_PWM_DUTY_LSB +: 8];
        end
        default: senseSel_r <= senseSel_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (rdSetup) begin
      case (paddr)
        `OCM_OFF_HW_SETUP: prdata <= {28'h0000000, lampSel_r, sleep_r, 1'b0};
        `OCM_OFF_CHAN_SW: prdata <= {26'h0000000, swBits_r};
        `OCM_OFF_IN_EXT_CFG: prdata <= {29'h00000000, compat_r, gateSel_r, mapSel_r};
        `OCM_OFF_DIAG_CFG: prdata <= {29'h00000000, senseSel_r};
        `OCM_OFF_PWM_SETUP: prdata <= {31'h00000000, pwmRun_r};
        `OCM_OFF_PWM_EXT0: prdata <= {16'h0000, pwmDuty_r[0], pwmPer_r[0]};
        `OCM_OFF_PWM_EXT1: prdata <= {16'h0000, pwmDuty_r[1], pwmPer_r[1]};
        `OCM_OFF_STATUS: prdata <= {18'h00000, limpS, sleep_r, diag_r, extDrive_r, fault_r, chanOn_r};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // input matrix: map pins, then or/and with the switch bits
  // ----------------------------------------------------------------
  assign pinDrv = mapPins(pinS, mapSel_r);
  assign pinMask = mapPins(3'b111, mapSel_r);

  for (genvar g = 0; g < 6; g++) begin : gReq
    // gating applies only where a pin is mapped; others follow their bit
    assign chanReq[g] = gateSel_r ? (swBits_r[g] && (pinDrv[g] || !pinMask[g]))
                                  : (swBits_r[g] || pinDrv[g]);
  end

  // ----------------------------------------------------------------
  // channel state: held while inverse current flows
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      chanOn_r <= 4'h0;
    end else begin
      // a channel with inverse current keeps its state, the others follow their request
      chanOn_r <= (chanOn_r & inverseS) | (chanReq[3:0] & ~inverseS);
    end
  end
  assign chanOn = chanOn_r;

  // ----------------------------------------------------------------
  // fault flags, suppressed during inverse current
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fault_r <= 4'h0;
    end else begin
      fault_r <= faultS & ~inverseS;
    end
  end
  assign faultFlag = fault_r;

  // ----------------------------------------------------------------
  // external drivers: drive and diagnosis lines
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      extDrive_r <= 2'b00;
      diag_r <= 2'b00;
    end else begin
      extDrive_r <= supplyS ? (chanReq[5:4] | pwmBus.pwmOut) : 2'b00;
      if (!supplyS) begin
        diag_r <= 2'b00;
      end else if (compat_r) begin
        case (senseSel_r)
          `OCM_SENSE_EXT0: diag_r <= 2'b01;
          `OCM_SENSE_EXT1: diag_r <= 2'b11;
          default: diag_r <= 2'b00;
        endcase
      end else begin
        diag_r <= {senseSel_r == `OCM_SENSE_EXT1, senseSel_r == `OCM_SENSE_EXT0};
      end
    end
  end
  assign extDriveCtl = extDrive_r;
  assign extDiagEnable = diag_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence rstWrite;
    wrEn && paddr == `OCM_OFF_HW_SETUP && pwdata[`OCM_HW_RST_BIT];
  endsequence
  sequence rstDone;
    softRst_r ##1 (swBits_r == 6'h00 && !mapSel_r && senseSel_r == `OCM_SENSE_DEFAULT);
  endsequence
  chk_reset_trigger: assert property (rstWrite |=> rstDone) else $error("bank not cleared by trigger");
  chk_sleep_flag: assert property (sleepNxt |=> sleepFlag) else $error("sleep flag not set in stand-by");
  chk_awake_flag: assert property (!sleepNxt |=> !sleepFlag) else $error("sleep flag set while awake");
  chk_direct_or: assert property (!mapSel_r && !gateSel_r && !inverseS[1] |=>
    chanOn[1] == $past(pinS[0] || swBits_r[1]))
    else $error("direct mapping of pin one wrong");
  chk_ch0_bit_only: assert property (!mapSel_r && !swBits_r[0] && !inverseS[0] |=> !chanOn[0])
    else $error("channel 0 on without its bit");
  chk_gate_and: assert property (gateSel_r && !mapSel_r && !inverseS[2] |=>
    chanOn[2] == $past(pinS[1] && swBits_r[2]))
    else $error("gated channel not bit and pin");
  chk_assigned_pin3: assert property (mapSel_r && !gateSel_r && pinS[2] && !inverseS[3] && supplyS |=>
    chanOn[3] && extDriveCtl == 2'b11)
    else $error("pin three not driving its group");
  chk_inverse_hold: assert property (inverseS[0] |=> $stable(chanOn[0]) && !faultFlag[0])
    else $error("inverse current changed state or flagged");
  chk_ext_supply: assert property (!supplyS |=> extDriveCtl == 2'b00) else $error("ext drive unpowered");
  chk_compat_diag: assert property (compat_r && supplyS && senseSel_r == `OCM_SENSE_EXT1 |=>
    extDiagEnable == 2'b11)
    else $error("compat diag lines wrong for ext1");
  chk_wake_map: assert property (wake && !wrEn && !regClear |=> !mapSel_r) else $error("map kept on wake");
endmodule

// *** dv/ocm_host_pins.sv ***
// host pin driver model facing the matrix pins
`timescale 1ns/1ps
module ocm_host_pins (
  input wire logic clock, // system clock
  input wire logic [12:0] pinReq, // requested pin levels
  output logic [12:0] pinOut // levels seen on the pins
);
  // ----------------------------------------------------------------
  // pin port
  // ----------------------------------------------------------------
  initial pinOut = 13'h0010; // supply present, all pins low
  // pins move only just after a rising edge, as a host port does
  always @(posedge clock) begin
    pinOut <= pinReq;
  end
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the output channel input matrix
`timescale 1ns/1ps
`include "ocm_consts.svh"
module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clock = 1'b0; // system clock
  logic resetn = 1'b0; // reset, active low
  logic [7:0] paddr = 8'h00; // apb address
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
  logic [31:0] pwdata = 32'h0, prdata, rd; // apb data, last read
  logic pready, pslverr, err; // apb answer, last error
  logic [12:0] pinReq = 13'h0010; // fault, inverse, supply, limp, pins
  logic [12:0] pinOut; // pin levels from the host model
  logic [3:0] chanOn, faultFlag; // channel outputs
  logic [1:0] lampLed, extDriveCtl, extDiagEnable; // profile and ext driver
  logic sleepFlag; // stand-by
  int miscompares = 0, check_count = 0; // result counters
  always #2.5 clock = ~clock;
  ocm_host_pins host_u (.clock(clock), .pinReq(pinReq), .pinOut(pinOut));
  ocm_output_matrix dut_u (.clock(clock), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .inPinOne(pinOut[0]), .inPinTwo(pinOut[1]), .inPinThree(pinOut[2]), .limpHomePin(pinOut[3]),
    .logicSupplyOk(pinOut[4]), .inverseCur(pinOut[8:5]), .chanFault(pinOut[12:9]), .chanOn(chanOn),
    .lampLed(lampLed), .extDriveCtl(extDriveCtl), .extDiagEnable(extDiagEnable), .faultFlag(faultFlag),
    .sleepFlag(sleepFlag));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  // set pins and let them pass the synchroniser
  task automatic pins(input logic [12:0] v);
    @(posedge clock);
    pinReq <= v;
    repeat (6) @(posedge clock);
  endtask
  // print counts and verdict, then stop
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    apb(1'b0, `OCM_OFF_HW_SETUP, 32'h0);
    chk(8'(rd[1]), 8'h01);
    apb(1'b0, `OCM_OFF_DIAG_CFG, 32'h0);
    chk(rd[7:0], 8'h07);
    apb(1'b0, 8'h20, 32'h0);
    chk(8'(err), 8'h01);
    $display("test reset done");
    pins(13'h0017);
    chk(8'(chanOn), 8'h0E);
    chk(8'(extDriveCtl), 8'h00);
    chk(8'(sleepFlag), 8'h00);
    pins(13'h0010);
    apb(1'b1, `OCM_OFF_DIAG_CFG, 32'h0);
    apb(1'b1, `OCM_OFF_CHAN_SW, 32'h3F);
    chk(8'(chanOn), 8'h0F);
    chk(8'(extDriveCtl), 8'h03);
    apb(1'b1, `OCM_OFF_IN_EXT_CFG, 32'h2);
    pins(13'h0012);
    chk(8'(chanOn), 8'h05);
    apb(1'b1, `OCM_OFF_CHAN_SW, 32'h0);
    apb(1'b1, `OCM_OFF_IN_EXT_CFG, 32'h1);
    pins(13'h0011);
    chk(8'(chanOn), 8'h01);
    pins(13'h0014);
    chk(8'(chanOn), 8'h0C);
    chk(8'(extDriveCtl), 8'h03);
    pins(13'h0004);
    chk(8'(extDriveCtl), 8'h00);
    $display("test mapping done");
    pins(13'h0010);
    apb(1'b1, `OCM_OFF_HW_SETUP, 32'hC);
    chk(8'(lampLed), 8'h03);
    apb(1'b1, `OCM_OFF_IN_EXT_CFG, 32'h4);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `OCM_OFF_DIAG_CFG, 32'(i + 4) & 32'h6 | 32'(i == 1 ? 1 : 0));
      chk(8'(extDiagEnable), i == 0 ? 8'h01 : i == 1 ? 8'h03 : 8'h00);
    end
    apb(1'b1, `OCM_OFF_IN_EXT_CFG, 32'h0);
    apb(1'b1, `OCM_OFF_DIAG_CFG, 32'h5);
    chk(8'(extDiagEnable), 8'h02);
    apb(1'b1, `OCM_OFF_PWM_EXT0, 32'h0100);
    apb(1'b1, `OCM_OFF_PWM_SETUP, 32'h1);
    chk(8'(extDriveCtl), 8'h01);
    apb(1'b1, `OCM_OFF_PWM_SETUP, 32'h0);
    chk(8'(extDriveCtl), 8'h00);
    $display("test profile and diag done");
    apb(1'b1, `OCM_OFF_CHAN_SW, 32'h1);
    pins(13'h0230);
    apb(1'b1, `OCM_OFF_CHAN_SW, 32'h0);
    chk(8'(chanOn), 8'h01);
    chk(8'(faultFlag), 8'h00);
    pins(13'h0010);
    chk(8'(chanOn), 8'h00);
    pins(13'h0210);
    chk(8'(faultFlag), 8'h01);
    apb(1'b1, `OCM_OFF_CHAN_SW, 32'h1);
    apb(1'b1, `OCM_OFF_IN_EXT_CFG, 32'h1);
    pins(13'h0012);
    chk(8'(chanOn), 8'h03);
    apb(1'b1, `OCM_OFF_HW_SETUP, 32'h2);
    chk(8'(chanOn), 8'h04);
    apb(1'b0, `OCM_OFF_CHAN_SW, 32'h0);
    chk(rd[7:0], 8'h00);
    apb(1'b0, `OCM_OFF_IN_EXT_CFG, 32'h0);
    chk(rd[7:0], 8'h00);
    pins(13'h0010);
    chk(8'(sleepFlag), 8'h01);
    apb(1'b1, `OCM_OFF_IN_EXT_CFG, 32'h1);
    pins(13'h0014);
    chk(8'(chanOn), 8'h08);
    pins(13'h001A);
    apb(1'b1, `OCM_OFF_CHAN_SW, 32'h1);
    chk(8'(chanOn), 8'h04);
    apb(1'b0, `OCM_OFF_STATUS, 32'h0);
    chk(rd[7:0], 8'h04);
    chk(rd[15:8], 8'h20);
    $display("test inverse, reset and sleep done");
    wrap_up();
  end
  // watchdog against a hang
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
endmodule
